/* File: shared/pcd_params.svh */
// Timing, width and reset constants for the pulse count dimming controller.
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH
`define PCD_CLK_PERIOD_NS      10
`define PCD_GLITCH_NS          200
`define PCD_GLITCH_CYC         ((`PCD_GLITCH_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_SHUTDOWN_US        800
`define PCD_SHUTDOWN_CYC       ((`PCD_SHUTDOWN_US * 1000) / `PCD_CLK_PERIOD_NS)
`define PCD_LEVEL_W            4
`define PCD_SINKS              6
`define PCD_LEVEL_RESET        4'h0
`define PCD_LEVEL_LAST         4'hF
`define PCD_FULL_CURRENT_UA    20000
`define PCD_STEP_UA            1250
`endif

/* File: shared/pcd_pkg.sv */
// Types shared by the pulse count dimming controller.
package pcd_pkg;
   typedef enum logic [1:0] {
      PCD_OFF    = 2'b00,
      PCD_ON     = 2'b01
   } pcd_state_t;

   typedef struct packed {
      logic       enabled;
      logic [3:0] level;
   } pcd_drive_t;
endpackage

/* File: rtl/pcd_deglitch.sv */
// Synchroniser and stability filter for the enable pin.
`timescale 1ns/1ps
`include "pcd_params.svh"
module pcd_deglitch #(
   parameter int STABLE_CYC = `PCD_GLITCH_CYC
) (
   // Clock, reset and enable.
   input  wire logic i_clock,
   input  wire logic i_srst,
   input  wire logic i_ce,
   // Raw pin and filtered level.
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   logic          sync1_reg;
   logic          sync2_reg;
   logic [CW-1:0] cnt_reg;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else if (i_ce) begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
      end
   end

   // A change is taken only once it has held for STABLE_CYC cycles.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         cnt_reg <= '0;
         o_level <= 1'b0;
         o_rise  <= 1'b0;
      end else if (i_ce) begin
         o_rise <= 1'b0;
         if (sync2_reg == o_level) begin
            cnt_reg <= '0;
         end else if (cnt_reg == CW'(STABLE_CYC - 1)) begin
            cnt_reg <= '0;
            o_level <= sync2_reg;
            o_rise  <= sync2_reg;
         end else begin
            cnt_reg <= cnt_reg + CW'(1);
         end
      end
   end
endmodule

/* File: rtl/pcd_ctrl.sv */
// Top of the pulse count dimming controller: edge counting, level hold and shutdown.
`timescale 1ns/1ps
`include "pcd_params.svh"
////////////////////////////////////////////////////////////////////////////////
module pcd_ctrl
   import pcd_pkg::*;
#(
   parameter int GLITCH_CYC   = `PCD_GLITCH_CYC,
   parameter int SHUTDOWN_CYC = `PCD_SHUTDOWN_CYC,
   parameter int SINKS        = `PCD_SINKS
) (
   // Clock, reset and enable.
   input  wire logic           i_clock,
   input  wire logic           i_srst,
   input  wire logic           i_ce,
   // Enable pin from the host.
   input  wire logic           i_enable_pin,
   // Sink drive.
   output pcd_pkg::pcd_drive_t o_drive,
   output logic [SINKS-1:0]    o_sink_on,
   output logic [3:0]          o_level,
   output logic [14:0]         o_current_ua,
   output logic                o_enabled
);
   import pcd_pkg::*;

   localparam int SW = $clog2(SHUTDOWN_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   logic          pin_level;
   logic          pin_rise;
   pcd_state_t    state_reg;
   logic [3:0]    level_reg;
   logic [SW-1:0] low_cnt_reg;
   logic          shut_now;

   pcd_deglitch #(
      .STABLE_CYC (GLITCH_CYC)
   ) u_deglitch (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_pin   (i_enable_pin),
      .o_level (pin_level),
      .o_rise  (pin_rise)
   );

   // Current in microamps for a level; level 0 is full scale.
   function automatic logic [14:0] pcd_current(input logic [3:0] lvl);
      pcd_current = 15'(`PCD_FULL_CURRENT_UA - `PCD_STEP_UA * int'(lvl));
   endfunction

   assign shut_now = (low_cnt_reg == SW'(SHUTDOWN_CYC - 1)) && !pin_level;

   ////////////////////////////////////////////////////////////////////////////
   // Low time counter for shutdown detection.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         low_cnt_reg <= '0;
      end else if (i_ce) begin
         if (pin_level || state_reg == PCD_OFF) begin
            low_cnt_reg <= '0;
         end else if (!shut_now) begin
            low_cnt_reg <= low_cnt_reg + SW'(1);
         end else begin
            low_cnt_reg <= '0;
         end
      end
   end

   // Operating state.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_reg <= PCD_OFF;
      end else if (i_ce) begin
         unique case (state_reg)
            PCD_OFF: begin
               if (pin_rise) begin
                  state_reg <= PCD_ON;
               end
            end
            PCD_ON: begin
               if (shut_now) begin
                  state_reg <= PCD_OFF;
               end
            end
            default: begin
               state_reg <= PCD_OFF;
            end
         endcase
      end
   end

   // Brightness level: the enabling edge leaves level 0, each later edge advances it by one and wraps.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         level_reg <= `PCD_LEVEL_RESET;
      end else if (i_ce) begin
         if (state_reg == PCD_OFF) begin
            level_reg <= `PCD_LEVEL_RESET;
         end else if (pin_rise) begin
            level_reg <= level_reg + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs, one cycle behind the state.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_enabled    <= 1'b0;
         o_level      <= 4'h0;
         o_current_ua <= 15'h0000;
         o_sink_on    <= '0;
         o_drive      <= '0;
      end else if (i_ce) begin
         o_enabled    <= (state_reg == PCD_ON);
         o_level      <= (state_reg == PCD_ON) ? level_reg : 4'h0;
         o_current_ua <= (state_reg == PCD_ON) ? pcd_current(level_reg) : 15'h0000;
         o_sink_on    <= {SINKS{state_reg == PCD_ON}};
         o_drive      <= '{enabled: (state_reg == PCD_ON), level: (state_reg == PCD_ON) ? level_reg : 4'h0};
      end
   end
endmodule

/* File: verif/pcd_ctrl_sva.sv */
// Port checker for the pulse count dimming controller.
`timescale 1ns/1ps
module pcd_ctrl_sva
   import pcd_pkg::*;
#(parameter int GLITCH_CYC = 20, parameter int SHUTDOWN_CYC = 80000, parameter int SINKS = 6) (
   // Watched ports.
   input wire logic             i_clock,
   input wire logic             i_srst,
   input wire logic             i_enable_pin,
   input wire logic [SINKS-1:0] o_sink_on,
   input wire logic [3:0]       o_level,
   input wire logic [14:0]      o_current_ua,
   input wire logic             o_enabled
);
   int hi_n;
   int lo_n;
   // Cycles the raw pin has spent high or low without a break.
   always_ff @(posedge i_clock) begin
      hi_n <= i_enable_pin ? hi_n + 1 : 0;
      lo_n <= i_enable_pin ? 0 : lo_n + 1;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   chk_sink_match: assert property (o_sink_on == {SINKS{o_enabled}}) else $error("sinks");
   chk_current_map: assert property (o_enabled |-> o_current_ua == 15'(20000 - 1250 * o_level))
      else $error("current");
   chk_off_zero: assert property (!o_enabled |-> o_current_ua == 0 && o_level == 0) else $error("off");
   chk_step_wrap: assert property (o_enabled && $past(o_enabled) && $changed(o_level)
      |-> o_level == $past(o_level) + 4'h1) else $error("step");
   chk_edge_only: assert property (o_enabled && ($changed(o_level) || !$past(o_enabled))
      |-> hi_n >= GLITCH_CYC && hi_n <= GLITCH_CYC + 8) else $error("edge");
   chk_enable_full: assert property ($rose(o_enabled) |-> o_level == 0) else $error("first step");
   chk_shutdown_delay: assert property (!$past(i_srst) && $fell(o_enabled)
      |-> lo_n >= SHUTDOWN_CYC && lo_n <= SHUTDOWN_CYC + GLITCH_CYC + 8) else $error("shutdown");
   chk_stay_off: assert property (lo_n > SHUTDOWN_CYC + GLITCH_CYC + 8 |-> !o_enabled) else $error("on");
   cover property ($rose(o_enabled));
   cover property ($fell(o_enabled));
   cover property (o_enabled && $past(o_level) == 4'hF && o_level == 4'h0);
endmodule
bind pcd_ctrl pcd_ctrl_sva #(.GLITCH_CYC(GLITCH_CYC), .SHUTDOWN_CYC(SHUTDOWN_CYC), .SINKS(SINKS)) chk (
   .i_clock(i_clock), .i_srst(i_srst), .i_enable_pin(i_enable_pin), .o_sink_on(o_sink_on),
   .o_level(o_level), .o_current_ua(o_current_ua), .o_enabled(o_enabled));

/* File: verif/pcd_host.sv */
// Host model that drives the enable pin with dimming pulses.
`timescale 1ns/1ps
module pcd_host (
   // Clock and pin.
   input  wire logic i_clock,
   output logic      o_pin
);
   initial o_pin = 1'b0;
   // Each pulse is a low gap then a high time, leaving the pin high.
   task automatic pulses(input int n, input int lo, input int hi);
      repeat (n) begin
         @(posedge i_clock) o_pin <= 1'b0;
         repeat (lo) @(posedge i_clock);
         o_pin <= 1'b1;
         repeat (hi) @(posedge i_clock);
      end
   endtask
   task automatic idle(input int c);
      @(posedge i_clock) o_pin <= 1'b0;
      repeat (c) @(posedge i_clock);
   endtask
endmodule

/* File: verif/pcd_ctrl_test.sv */
// Self-checking bench for the pulse count dimming controller.
`timescale 1ns/1ps
module pcd_ctrl_test;
   import pcd_pkg::*;
   localparam int GL = 20;
   localparam int SD = 50;
   localparam int HI = 30;
   logic        i_clock;
   logic        i_srst = 1'b1;
   logic        i_ce = 1'b1;
   logic        i_enable_pin;
   pcd_drive_t  o_drive;
   logic [5:0]  o_sink_on;
   logic [3:0]  o_level;
   logic [14:0] o_current_ua;
   logic        o_enabled;
   int          bad_count;
   int          checks;
   int          n_tab [7] = '{8, 4, 4, 8, 8, 15, 1};
   logic [3:0]  lv_tab [7] = '{4'h8, 4'hC, 4'h0, 4'h8, 4'h0, 4'hF, 4'h0};
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   pcd_host host (.i_clock(i_clock), .o_pin(i_enable_pin));
   pcd_ctrl #(.GLITCH_CYC(GL), .SHUTDOWN_CYC(SD)) uut (.i_clock(i_clock), .i_srst(i_srst), .i_ce(i_ce),
      .i_enable_pin(i_enable_pin), .o_drive(o_drive), .o_sink_on(o_sink_on), .o_level(o_level),
      .o_current_ua(o_current_ua), .o_enabled(o_enabled));
   task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic expect_on(input logic [3:0] lvl);
      check("level", o_level, lvl);
      check("drive", o_drive, {1'b1, lvl});
      check("current", o_current_ua, 15'(20000 - 1250 * lvl));
      check("sinks", o_sink_on, 6'h3F);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clock);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge i_clock);
      check("reset enabled", o_enabled, 15'h0);
      check("reset current", o_current_ua, 15'h0);
      i_srst <= 1'b0;
      host.pulses(1, 2, 5);
      host.idle(40);
      check("spike", o_enabled, 15'h0);
      host.pulses(1, 2, HI);
      expect_on(4'h0);
      $display("test enable done");
      foreach (n_tab[i]) begin
         host.pulses(n_tab[i], HI, HI);
         expect_on(lv_tab[i]);
      end
      $display("test rows done");
      i_ce <= 1'b0;
      host.pulses(1, HI, HI);
      expect_on(4'h0);
      i_ce <= 1'b1;
      host.pulses(1, 5, 200);
      expect_on(4'h0);
      host.pulses(3, HI, HI);
      host.idle(SD + GL + 20);
      check("shutdown enabled", o_enabled, 15'h0);
      check("shutdown current", o_current_ua, 15'h0);
      check("shutdown level", o_level, 15'h0);
      host.pulses(1, 2, HI);
      expect_on(4'h0);
      $display("test shutdown done");
      tally_and_finish();
   end
endmodule
